// ### esc_defines.vh
`ifndef ESC_DEFINES_VH
`define ESC_DEFINES_VH

// command codes on cmd_code
`define ESC_CMD_CLS        4'h0
`define ESC_CMD_ESE_WR     4'h1
`define ESC_CMD_ESE_RD     4'h2
`define ESC_CMD_ESR_RD     4'h3
`define ESC_CMD_IDN_RD     4'h4
`define ESC_CMD_OPC        4'h5
`define ESC_CMD_OPC_RD     4'h6
`define ESC_CMD_RCL        4'h7
`define ESC_CMD_SRE_WR     4'h8
`define ESC_CMD_SRE_RD     4'h9
`define ESC_CMD_STB_RD     4'hA

// event status bit positions (weight = 2**position)
`define ESC_BIT_PON        7
`define ESC_BIT_CME        5
`define ESC_BIT_EXE        4
`define ESC_BIT_DDE        3
`define ESC_BIT_QYE        2
`define ESC_BIT_OPC        0
`define ESC_STATUS_USED    8'hBD
`define ESC_STATUS_RST     8'h80
`define ESC_ENABLE_RST     8'h00

// status byte bit positions
`define ESC_STB_OPER       7
`define ESC_STB_MSS        6
`define ESC_STB_ESB        5
`define ESC_STB_MAV        4
`define ESC_STB_QUES       3
`define ESC_STB_ERRQ       2
`define ESC_SRE_MASK       8'hBC
`define ESC_SRE_RST        8'h00

// recall memory
`define ESC_RCL_MIN        8'h01
`define ESC_RCL_MAX        8'h28
`define ESC_MEM_DEPTH      40
`define ESC_MEM_AW         6
`define ESC_SP_W           16

// identification string
`define ESC_ASCII_ONE      8'h31
`define ESC_DATE_LEN       10
`define ESC_ID_LEN         44
`define ESC_ID_IW          6

`endif

// ### esc_setpoint_mem.v
`timescale 1ns/1ps
`include "esc_defines.vh"
module esc_setpoint_mem (
  input  wire                         mclk,
  input  wire                         ce,
  input  wire                         we,
  input  wire [`ESC_MEM_AW-1:0]       waddr,
  input  wire [4*`ESC_SP_W-1:0]       wdata,
  input  wire [`ESC_MEM_AW-1:0]       raddr,
  output reg  [4*`ESC_SP_W-1:0]       rdata
);
  reg [4*`ESC_SP_W-1:0] mem [0:`ESC_MEM_DEPTH-1];

  always @(posedge mclk) begin
    if (ce) begin
      if (we)
        mem[waddr] <= wdata;
      rdata <= mem[raddr];
    end
  end
endmodule

// ### esc_core.v
`timescale 1ns/1ps
`include "esc_defines.vh"
// Behaviour
// - status bits: PON7 CME5 EXE4 DDE3 QYE2 OPC0
// - each bit weighs two to its position
// - mask query returns held mask
// - enabled events OR into summary bit 5
// - status query returns then clears register
// - parse and internal faults set error bits
// - identity query returns comma separated string
// - calibration date holds up to ten characters
// - completion command sets bit 0 when idle
// - commands continue while completion is pending
// - completion query queues ASCII one when idle
// - completion query holds off later commands
// - recall 1..40 loads four stored settings
// - mask write 0..255, default zero
// - clear status keeps all enable masks
// - enabled status byte bits set bit 6
module esc_core #(
  parameter [47:0] MAKER_STR  = "MAKER0",  // arbitrary value
  parameter [23:0] MODEL_STR  = "PSU",
  parameter [31:0] VMAX_STR   = "0000",
  parameter [23:0] IMAX_STR   = "000",
  parameter [55:0] SERIAL_STR = "X000000",
  parameter [7:0]  FW_MAJOR   = "1",
  parameter [7:0]  FW_MINOR   = "0"
) (
  input  wire                   mclk,
  input  wire                   rst,
  input  wire                   ce,
  input  wire                   cmd_valid,
  input  wire [3:0]             cmd_code,
  input  wire [7:0]             cmd_arg,
  output reg                    cmd_ready,
  input  wire                   err_cme,
  input  wire                   err_exe,
  input  wire                   err_dde,
  input  wire                   err_qye,
  input  wire                   ops_busy,
  input  wire                   oper_sum,
  input  wire                   ques_sum,
  input  wire                   msg_avail,
  input  wire                   errq_nonempty,
  output reg                    clear_status,
  output reg                    resp_valid,
  output reg  [7:0]             resp_data,
  output reg                    resp_text,
  output reg                    resp_last,
  output reg  [7:0]             status_byte,
  input  wire                   date_we,
  input  wire [3:0]             date_idx,
  input  wire [7:0]             date_char,
  input  wire                   sav_we,
  input  wire [`ESC_MEM_AW-1:0] sav_addr,
  input  wire [63:0]            sav_data,
  output reg  [15:0]            vset,
  output reg  [15:0]            iset,
  output reg  [15:0]            ovp,
  output reg  [15:0]            ocp
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_IDN  = 2'd1;
  localparam [1:0] ST_OPCQ = 2'd2;

  reg  [1:0]             state_reg;
  reg  [7:0]             event_status_reg;
  reg  [7:0]             event_enable_reg;
  reg  [7:0]             sre_mask_reg;
  reg                    opc_pending_reg;
  reg  [`ESC_ID_IW-1:0]  id_idx_reg;
  reg                    rcl_load_reg;
  reg  [8*`ESC_DATE_LEN-1:0] date_reg;
  reg  [`ESC_MEM_AW-1:0] rcl_addr;
  wire [63:0]            mem_rdata;
  wire [8*`ESC_ID_LEN-1:0] id_vec;
  wire                   take;
  wire                   rcl_ok;
  wire                   bad_cmd;
  wire [7:0]             events;
  wire [7:0]             status_clr;
  wire                   esb;
  wire [7:0]             stb_low;
  wire                   idn_done;

  assign take    = cmd_valid && cmd_ready && (state_reg == ST_IDLE);
  assign rcl_ok  = (cmd_arg >= `ESC_RCL_MIN) && (cmd_arg <= `ESC_RCL_MAX);
  assign bad_cmd = (cmd_code > `ESC_CMD_STB_RD);

  // fixed-length identity string, date padded with spaces by default
  assign id_vec = {MAKER_STR, ",", MODEL_STR, "-", VMAX_STR, "-", IMAX_STR, " ",
                   date_reg, ",", SERIAL_STR, ",V", FW_MAJOR, ".", FW_MINOR, 8'h0A};
  assign idn_done = (id_idx_reg == `ESC_ID_LEN - 1);

  // parser and instrument faults, plus locally detected ones
  assign events[`ESC_BIT_PON] = 1'b0;
  assign events[6]            = 1'b0;
  assign events[`ESC_BIT_CME] = err_cme | (take & bad_cmd);
  assign events[`ESC_BIT_EXE] = err_exe | (take & (cmd_code == `ESC_CMD_RCL) & ~rcl_ok);
  assign events[`ESC_BIT_DDE] = err_dde;
  assign events[`ESC_BIT_QYE] = err_qye;
  assign events[1]            = 1'b0;
  // bit 0 only once all earlier work has finished
  assign events[`ESC_BIT_OPC] = opc_pending_reg & ~ops_busy;

  // read clears, clear-status clears; new events still land
  assign status_clr = (take && (cmd_code == `ESC_CMD_ESR_RD || cmd_code == `ESC_CMD_CLS))
                      ? 8'h00 : 8'hFF;

  assign esb = |(event_status_reg & event_enable_reg);
  assign stb_low = {oper_sum, 1'b0, esb, msg_avail, ques_sum, errq_nonempty, 2'b00};

  always @* begin
    rcl_addr = cmd_arg[`ESC_MEM_AW-1:0] - 6'd1;
  end

  esc_setpoint_mem u_mem (
    .mclk  (mclk),
    .ce    (ce),
    .we    (sav_we),
    .waddr (sav_addr),
    .wdata (sav_data),
    .raddr (rcl_addr),
    .rdata (mem_rdata)
  );

  always @(posedge mclk) begin
    if (rst) begin
      state_reg        <= ST_IDLE;
      event_status_reg <= `ESC_STATUS_RST;
      event_enable_reg <= `ESC_ENABLE_RST;
      sre_mask_reg     <= `ESC_SRE_RST;
      opc_pending_reg  <= 1'b0;
      id_idx_reg       <= {`ESC_ID_IW{1'b0}};
      rcl_load_reg     <= 1'b0;
      date_reg         <= {`ESC_DATE_LEN{8'h20}};
      cmd_ready        <= 1'b0;
      clear_status     <= 1'b0;
      resp_valid       <= 1'b0;
      resp_data        <= 8'h00;
      resp_text        <= 1'b0;
      resp_last        <= 1'b0;
      status_byte      <= 8'h00;
      vset             <= 16'h0000;
      iset             <= 16'h0000;
      ovp              <= 16'h0000;
      ocp              <= 16'h0000;
    end else if (ce) begin
      resp_valid   <= 1'b0;
      resp_last    <= 1'b0;
      clear_status <= 1'b0;
      rcl_load_reg <= 1'b0;
      // set wins over clear, unused bits forced low
      event_status_reg <= ((event_status_reg & status_clr) | events) & `ESC_STATUS_USED;
      if (events[`ESC_BIT_OPC])
        opc_pending_reg <= 1'b0;
      // master summary from enabled status byte bits
      status_byte <= stb_low | ({7'd0, |(stb_low & sre_mask_reg)} << `ESC_STB_MSS);
      if (date_we && (date_idx < `ESC_DATE_LEN))
        date_reg[8*(`ESC_DATE_LEN-1-date_idx) +: 8] <= date_char;
      if (rcl_load_reg) begin
        vset <= mem_rdata[63:48];
        iset <= mem_rdata[47:32];
        ovp  <= mem_rdata[31:16];
        ocp  <= mem_rdata[15:0];
      end
      case (state_reg)
        ST_IDLE: begin
          cmd_ready <= 1'b1;
          if (take) begin
            case (cmd_code)
              `ESC_CMD_CLS: clear_status <= 1'b1;
              `ESC_CMD_ESE_WR: event_enable_reg <= cmd_arg & `ESC_STATUS_USED;
              `ESC_CMD_ESE_RD: begin
                resp_valid <= 1'b1;
                resp_data  <= event_enable_reg;
                resp_text  <= 1'b0;
                resp_last  <= 1'b1;
              end
              `ESC_CMD_ESR_RD: begin
                resp_valid <= 1'b1;
                resp_data  <= event_status_reg;
                resp_text  <= 1'b0;
                resp_last  <= 1'b1;
              end
              `ESC_CMD_IDN_RD: begin
                state_reg  <= ST_IDN;
                cmd_ready  <= 1'b0;
                id_idx_reg <= {`ESC_ID_IW{1'b0}};
              end
              `ESC_CMD_OPC: opc_pending_reg <= 1'b1;
              `ESC_CMD_OPC_RD: begin
                state_reg <= ST_OPCQ;
                cmd_ready <= 1'b0;
              end
              `ESC_CMD_RCL: rcl_load_reg <= rcl_ok;
              `ESC_CMD_SRE_WR: sre_mask_reg <= cmd_arg & `ESC_SRE_MASK;
              `ESC_CMD_SRE_RD: begin
                resp_valid <= 1'b1;
                resp_data  <= sre_mask_reg;
                resp_text  <= 1'b0;
                resp_last  <= 1'b1;
              end
              `ESC_CMD_STB_RD: begin
                resp_valid <= 1'b1;
                resp_data  <= status_byte;
                resp_text  <= 1'b0;
                resp_last  <= 1'b1;
              end
              default: ;
            endcase
          end
        end
        ST_IDN: begin
          resp_valid <= 1'b1;
          resp_text  <= 1'b1;
          resp_data  <= id_vec[8*(`ESC_ID_LEN-1-id_idx_reg) +: 8];
          resp_last  <= idn_done;
          id_idx_reg <= id_idx_reg + 6'd1;
          if (idn_done) begin
            state_reg <= ST_IDLE;
            cmd_ready <= 1'b1;
          end
        end
        ST_OPCQ: begin
          if (!ops_busy) begin
            resp_valid <= 1'b1;
            resp_data  <= `ESC_ASCII_ONE;
            resp_text  <= 1'b1;
            resp_last  <= 1'b1;
            state_reg  <= ST_IDLE;
            cmd_ready  <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          cmd_ready <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ### esc_checker.sv
`timescale 1ns/1ps
module esc_checker (
  input wire        mclk,
  input wire        rst,
  input wire        ce,
  input wire        cmd_valid,
  input wire [3:0]  cmd_code,
  input wire [7:0]  cmd_arg,
  input wire        cmd_ready,
  input wire        ops_busy,
  input wire        oper_sum,
  input wire        clear_status,
  input wire        resp_valid,
  input wire [7:0]  resp_data,
  input wire        resp_text,
  input wire        resp_last,
  input wire [7:0]  status_byte,
  input wire [15:0] vset
);
  wire tk = ce && cmd_valid && cmd_ready;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_sum_lag;
    ce && $past(ce) && !$past(rst) |-> status_byte[7] == $past(oper_sum);
  endproperty
  a_sum_lag: assert property (p_sum_lag) else $error("status byte bit 7 lag wrong");
  property p_bin_resp;
    tk && cmd_code == 4'h2 |=> resp_valid && resp_last && !resp_text;
  endproperty
  a_bin_resp: assert property (p_bin_resp) else $error("mask query reply missing");
  property p_esr_nu;
    tk && cmd_code == 4'h3 |=> resp_valid && (resp_data & 8'h42) == 8'h00;
  endproperty
  a_esr_nu: assert property (p_esr_nu) else $error("unused status bits not zero");
  property p_opc_hold;
    tk && cmd_code == 4'h6 ##1 ops_busy [*2] |-> !resp_valid && !cmd_ready;
  endproperty
  a_opc_hold: assert property (p_opc_hold) else $error("completion query not held");
  property p_cls;
    tk && cmd_code == 4'h0 |=> clear_status && !resp_valid;
  endproperty
  a_cls: assert property (p_cls) else $error("clear pulse missing");
  property p_idn_end;
    tk && cmd_code == 4'h4 |-> ##45 resp_valid && resp_last && resp_data == 8'h0A;
  endproperty
  a_idn_end: assert property (p_idn_end) else $error("ident string end wrong");
  property p_idn_busy;
    tk && cmd_code == 4'h4 |=> !cmd_ready [*8];
  endproperty
  a_idn_busy: assert property (p_idn_busy) else $error("command taken during ident");
  property p_rcl_bad;
    tk && cmd_code == 4'h7 && (cmd_arg == 8'h00 || cmd_arg > 8'h28) |=> ##1 $stable(vset);
  endproperty
  a_rcl_bad: assert property (p_rcl_bad) else $error("bad recall changed setting");
  c_idn: cover property (tk && cmd_code == 4'h4);
  c_opcq: cover property (tk && cmd_code == 4'h6);
  c_rcl: cover property (tk && cmd_code == 4'h7);
endmodule
bind esc_core esc_checker esc_checker_inst (.mclk(mclk), .rst(rst), .ce(ce),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
  .ops_busy(ops_busy), .oper_sum(oper_sum), .clear_status(clear_status),
  .resp_valid(resp_valid), .resp_data(resp_data), .resp_text(resp_text),
  .resp_last(resp_last), .status_byte(status_byte), .vset(vset));

// ### esc_ctl_model.sv
`timescale 1ns/1ps
module esc_ctl_model (
  input  wire       mclk,
  input  wire       rst,
  input  wire       go,
  input  wire [7:0] len,
  input  wire       resp_valid,
  input  wire [7:0] resp_data,
  input  wire       resp_text,
  output wire       ops_busy,
  output reg        got_one
);
  reg [7:0] cnt_reg;
  assign ops_busy = cnt_reg != 8'h00;
  always @(posedge mclk) begin
    if (rst || go) begin
      cnt_reg <= rst ? 8'h00 : len;
      got_one <= 1'b0;
    end else begin
      if (ops_busy) cnt_reg <= cnt_reg - 8'h01;
      // controller watches for the queued one
      if (resp_valid && resp_text && resp_data == 8'h31) got_one <= 1'b1;
    end
  end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count = cmp_count + 1; if ((g) !== (e)) begin \
  err_count = err_count + 1; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb_top;
  reg mclk, rst, ce, cmd_valid, go, oper_sum, date_we, sav_we;
  reg [3:0] cmd_code, date_idx, e4;
  reg [7:0] cmd_arg, len, date_char, d, lst;
  wire cmd_ready, ops_busy, clear_status, resp_valid, resp_text, resp_last, got_one;
  wire [7:0] resp_data, status_byte;
  wire [15:0] vset, iset, ovp, ocp;
  integer err_count, cmp_count, cyc, k;
  esc_core esc_core_inst (.mclk(mclk), .rst(rst), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .err_cme(e4[3]),
    .err_exe(e4[2]), .err_dde(e4[1]), .err_qye(e4[0]), .ops_busy(ops_busy),
    .oper_sum(oper_sum), .ques_sum(1'b0), .msg_avail(1'b0), .errq_nonempty(1'b0),
    .clear_status(clear_status), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_text(resp_text), .resp_last(resp_last), .status_byte(status_byte),
    .date_we(date_we), .date_idx(date_idx), .date_char(date_char), .sav_we(sav_we),
    .sav_addr(6'h27), .sav_data(64'h123456789ABCDEF0), .vset(vset), .iset(iset),
    .ovp(ovp), .ocp(ocp));
  esc_ctl_model esc_ctl_model_inst (.mclk(mclk), .rst(rst), .go(go), .len(len),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_text(resp_text),
    .ops_busy(ops_busy), .got_one(got_one));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_count = err_count + 1;
      print_verdict;
    end
  end
  // valid stays low across one edge, then offer at a falling edge until ready is seen
  task cmd(input [3:0] c, input [7:0] a);
    integer n;
    begin
      n = 0;
      @(negedge mclk);
      cmd_code = c;
      cmd_arg = a;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1 && n < 100) begin
        n = n + 1;
        @(negedge mclk);
      end
      if (n == 100) err_count = err_count + 1;
      @(negedge mclk);
      cmd_valid = 1'b0;
    end
  endtask
  task q(input [3:0] c, input [7:0] e);
    begin
      cmd(c, 8'h00);
      `CHK("reply", e, resp_data)
    end
  endtask
  task pulse(input [3:0] v);
    begin
      e4 = v;
      @(negedge mclk);
      e4 = 4'h0;
      repeat (3) @(negedge mclk);
    end
  endtask
  task t_mask;
    begin
      cmd(4'h1, 8'hFF);
      q(4'h2, 8'hBD);
      oper_sum = 1'b1;
      pulse(4'h8);
      `CHK("esb", 1'b1, status_byte[5])
      `CHK("oper", 1'b1, status_byte[7])
      cmd(4'h8, 8'hFF);
      q(4'h9, 8'hBC);
      q(4'hA, 8'hE0);
      oper_sum = 1'b0;
      cmd(4'h1, 8'h00);
      repeat (3) @(negedge mclk);
      `CHK("esb off", 1'b0, status_byte[5])
      q(4'h3, 8'h20);
      pulse(4'hF);
      q(4'h3, 8'h3C);
      q(4'h3, 8'h00);
      cmd(4'hB, 8'h00);
      q(4'h3, 8'h20);
    end
  endtask
  task t_opc;
    begin
      go = 1'b1;
      len = 8'h06;
      @(negedge mclk);
      go = 1'b0;
      cmd(4'h5, 8'h00);
      q(4'h3, 8'h00);
      repeat (8) @(negedge mclk);
      q(4'h3, 8'h01);
      go = 1'b1;
      @(negedge mclk);
      go = 1'b0;
      cmd(4'h6, 8'h00);
      `CHK("held off", 1'b0, cmd_ready)
      k = 0;
      while (got_one !== 1'b1 && k < 30) begin
        k = k + 1;
        @(negedge mclk);
      end
      `CHK("one queued", 1'b1, got_one)
    end
  endtask
  task t_idn;
    begin
      date_we = 1'b1;
      @(negedge mclk);
      date_we = 1'b0;
      cmd(4'h4, 8'h00);
      k = 0;
      repeat (50) begin
        @(negedge mclk);
        if (resp_valid) begin
          if (k == 20) d = resp_data;
          if (resp_last) lst = resp_data;
          k = k + 1;
        end
      end
      `CHK("ident bytes", 8'd44, k[7:0])
      `CHK("date char", 8'h30, d)
      `CHK("ident end", 8'h0A, lst)
    end
  endtask
  task t_rcl;
    begin
      sav_we = 1'b1;
      @(negedge mclk);
      sav_we = 1'b0;
      cmd(4'h7, 8'h28);
      repeat (3) @(negedge mclk);
      `CHK("recalled", 64'h123456789ABCDEF0, {vset, iset, ovp, ocp})
      cmd(4'h7, 8'h29);
      repeat (3) @(negedge mclk);
      `CHK("kept", 16'h1234, vset)
      q(4'h3, 8'h10);
    end
  endtask
  task t_cls;
    begin
      cmd(4'h1, 8'h3C);
      pulse(4'h1);
      cmd(4'h0, 8'h00);
      `CHK("clear pulse", 1'b1, clear_status)
      q(4'h3, 8'h00);
      q(4'h2, 8'h3C);
      ce = 1'b0;
      pulse(4'h8);
      ce = 1'b1;
      q(4'h3, 8'h00);
    end
  endtask
  initial begin
    {cmd_valid, go, oper_sum, date_we, sav_we, cmd_code, e4, cmd_arg} = 0;
    {len, date_idx} = 0;
    date_char = 8'h30;
    ce = 1'b1;
    {err_count, cmp_count, cyc} = 0;
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    q(4'h3, 8'h80);
    q(4'h2, 8'h00);
    t_mask;
    t_opc;
    t_idn;
    t_rcl;
    t_cls;
    print_verdict;
  end
endmodule
